/* File: core/brs_top.sv */
// Purpose: reset merge, register store and reconfiguration sequencer
// Assumes: AXI4-Lite master and a simple target-port initiator on clk_sys
// Notes:   board inputs are asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none
module brs_top
	import brs_pkg::*;
#(
	parameter int LONG_WAIT_CYC = LONG_CYC
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]   s_awaddr,
	input  wire logic                s_awvalid,
	output logic                     s_awready,
	input  wire logic [31:0]         s_wdata,
	input  wire logic [3:0]          s_wstrb,
	input  wire logic                s_wvalid,
	output logic                     s_wready,
	output logic [1:0]               s_bresp,
	output logic                     s_bvalid,
	input  wire logic                s_bready,
	input  wire logic [ADDR_W-1:0]   s_araddr,
	input  wire logic                s_arvalid,
	output logic                     s_arready,
	output logic [31:0]              s_rdata,
	output logic [1:0]               s_rresp,
	output logic                     s_rvalid,
	input  wire logic                s_rready,
	output logic                     lb_not_ready,
	// Target-only second port
	input  wire logic                pci_req,
	input  wire logic                pci_we,
	input  wire logic                pci_cfg,
	input  wire logic [5:0]          pci_idx,
	input  wire logic [31:0]         pci_wdata,
	output logic                     pci_ack,
	output logic [31:0]              pci_rdata,
	// Board inputs, asynchronous
	input  wire logic                debug_hard_reset_in_n,
	input  wire logic                debug_attached,
	input  wire logic                board_power_ok,
	input  wire logic                core_supply_power_good,
	input  wire logic                cpu_out_of_reset_flag,
	input  wire logic [2:0]          power_good,
	input  wire logic                reset_button_n,
	input  wire logic [1:0]          clock_switch,
	input  wire logic [3:0]          direct_switch,
	// Board outputs
	output brs_resets_t              resets,
	output brs_cfg_pins_t            cfg_pins,
	output logic [3:0]               direct_cfg,
	output logic [15:0]              clkgen_init,
	output logic                     drive_oe
);
	// ---------------------------------------------
	// Input synchronisers
	// ---------------------------------------------
	localparam int SYNC_W = 15;
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;
	assign async_in = {direct_switch, clock_switch, reset_button_n, power_good, cpu_out_of_reset_flag,
		core_supply_power_good, board_power_ok, debug_attached, debug_hard_reset_in_n};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= async_in[gi]; // [RULE23]
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate
	logic dbg_debug_hard_reset_in, dbg_att, pwr_on, core_pg, cpu_up, btn_rst;
	logic [2:0] pg;
	logic [1:0] clk_sw;
	logic [3:0] dir_sw;
	assign dbg_debug_hard_reset_in = ~sync_r[0];
	assign dbg_att = sync_r[1];
	assign pwr_on = sync_r[2];
	assign core_pg = sync_r[3];
	assign cpu_up = sync_r[4];
	assign pg = sync_r[7:5];
	assign btn_rst = ~sync_r[8];
	assign clk_sw = sync_r[10:9];
	assign dir_sw = sync_r[14:11];

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	logic [3:0]  ctrl_r;
	logic [4:0]  en_a_r, en_b_r;
	logic [6:0]  vcore_r;
	logic [15:0] clksel_r;
	logic [8:0]  speed_a_r; // core PLL [5:0], ref select [8:6]
	logic [6:0]  speed_b_r; // platform PLL [4:0], host [5], controller [6]
	logic [5:0]  boot_r;    // loc [1:0], seq [3:2], map [4], bank [5]
	logic        hard_reset_out_r;
	logic        sys_rst_r;

	typedef enum logic [4:0] {
		S_IDLE, S_QUIESCE, S_HOLD, S_VOLT, S_VOLT_WAIT, S_CLK, S_CLK_WAIT, S_PPLL, S_CORE_PLL_CHANGE_ENABLE,
		S_REF, S_REF_WAIT, S_BOOT_LOCATION, S_BOOT_SEQUENCE_SELECT, S_FLASH, S_HOST, S_CTLPIN, S_RELEASE, S_HELD
	} brs_state_t;
	brs_state_t state_r;

	function automatic logic [31:0] reg_read(input logic [5:0] idx);
		logic [31:0] v;
		v = '0;
		unique case (idx)
			IDX_CTRL:    v = 32'(ctrl_r);
			IDX_EN_A:    v = 32'(en_a_r);
			IDX_EN_B:    v = 32'(en_b_r);
			IDX_VCORE:   v = 32'(vcore_r);
			IDX_CLKSEL:  v = 32'(clksel_r);
			IDX_SPEED_A: v = 32'(speed_a_r);
			IDX_SPEED_B: v = 32'(speed_b_r);
			IDX_BOOT:    v = 32'(boot_r);
			IDX_STATUS:  v = {16'h0000, 3'h0, 5'(state_r), cpu_up, core_pg, dbg_att, pwr_on, pg, hard_reset_out_r};
			IDX_CLKINIT: v = 32'(clkgen_init);
			IDX_ID:      v = {DEVICE_ID, VENDOR_ID};
			default:     v = '0;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [5:0] idx);
		return idx <= IDX_ID;
	endfunction

	// ---------------------------------------------
	// AXI4-Lite slave and write arbitration
	// ---------------------------------------------
	logic [5:0]  aw_idx, ar_idx;
	logic        axi_wr, pci_take, pci_wr, any_wr;
	logic [5:0]  wr_idx;
	logic [31:0] wr_val, mask;
	assign aw_idx = s_awaddr[7:2];
	assign ar_idx = s_araddr[7:2];
	assign axi_wr = s_awvalid & s_wvalid & ~s_awready & ~s_bvalid;
	// Same-register collision: local bus wins, target port retries next cycle
	assign pci_take = pci_req & ~pci_ack & ~(axi_wr & pci_we & ~pci_cfg & (pci_idx == aw_idx)); // [RULE7]
	assign pci_wr = pci_take & pci_we & ~pci_cfg;
	assign mask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
	always_comb begin
		any_wr = axi_wr | pci_wr;
		wr_idx = pci_idx;
		wr_val = pci_wdata;
		if (axi_wr) begin
			wr_idx = aw_idx; // [RULE7]
			wr_val = (reg_read(aw_idx) & ~mask) | (s_wdata & mask);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OKAY;
		end else begin
			s_awready <= axi_wr;
			s_wready <= axi_wr;
			if (axi_wr) begin
				s_bvalid <= 1'b1;
				s_bresp <= mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= RESP_OKAY;
		end else begin
			s_arready <= s_arvalid & ~s_arready & ~s_rvalid;
			if (s_arvalid & ~s_arready & ~s_rvalid) begin
				s_rvalid <= 1'b1;
				s_rdata <= reg_read(ar_idx);
				s_rresp <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// High for one cycle, the first cycle in which the answer is presented
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lb_not_ready <= 1'b0;
		end else begin
			lb_not_ready <= ((s_awvalid & s_wvalid & ~s_bvalid & ~s_awready) | (s_arvalid & ~s_rvalid & ~s_arready)); // [RULE8]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pci_ack <= 1'b0;
			pci_rdata <= '0;
		end else begin
			pci_ack <= pci_take;
			if (pci_take) begin
				pci_rdata <= pci_cfg ? {DEVICE_ID, VENDOR_ID} : reg_read(pci_idx); // [RULE10]
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r <= '0;
			en_a_r <= '0;
			en_b_r <= '0;
			vcore_r <= '0;
			clksel_r <= '0;
			speed_a_r <= '0;
			speed_b_r <= '0;
			boot_r <= '0;
		end else if (any_wr) begin
			unique case (wr_idx)
				IDX_CTRL:    ctrl_r <= wr_val[3:0];
				IDX_EN_A:    en_a_r <= wr_val[4:0];
				IDX_EN_B:    en_b_r <= wr_val[4:0];
				IDX_VCORE:   vcore_r <= wr_val[6:0];
				IDX_CLKSEL:  clksel_r <= wr_val[15:0];
				IDX_SPEED_A: speed_a_r <= wr_val[8:0];
				IDX_SPEED_B: speed_b_r <= wr_val[6:0];
				IDX_BOOT:    boot_r <= wr_val[5:0];
				default:     ;
			endcase
		end
	end

	// ---------------------------------------------
	// Reset collector and output stage
	// ---------------------------------------------
	// Processor-cpu_out_of_reset_flag flag is status only, never a reset source
	logic reset_req;
	logic [TIMER_W-1:0] stretch_r;
	assign reset_req = dbg_debug_hard_reset_in | btn_rst | ~(&pg) | ~pwr_on; // [RULE3] [RULE4]
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stretch_r <= TIMER_W'(RESET_STRETCH_CYC);
			sys_rst_r <= 1'b1;
		end else if (reset_req) begin
			stretch_r <= TIMER_W'(RESET_STRETCH_CYC); // [RULE3]
			sys_rst_r <= 1'b1;
		end else if (stretch_r != '0) begin
			stretch_r <= stretch_r - 1'b1;
		end else begin
			sys_rst_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resets <= '{lb: 1'b1, mem: 1'b1, cf: 1'b1, hard: 1'b1, trst: 1'b1};
			drive_oe <= 1'b0;
		end else begin
			resets.lb <= sys_rst_r | ctrl_r[CTRL_RST_LB]; // [RULE6]
			resets.mem <= sys_rst_r | ctrl_r[CTRL_RST_MEM]; // [RULE6]
			resets.cf <= sys_rst_r | ctrl_r[CTRL_RST_CF]; // [RULE6]
			resets.hard <= sys_rst_r | hard_reset_out_r;
			// Debugger keeps its controller state across its own hard reset
			resets.trst <= (sys_rst_r | hard_reset_out_r) & ~dbg_att; // [RULE1] [RULE2]
			drive_oe <= pwr_on; // [RULE5]
		end
	end

	// ---------------------------------------------
	// Configuration switches
	// ---------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			direct_cfg <= '0;
			clkgen_init <= CLKINIT_POS0;
		end else begin
			direct_cfg <= dir_sw; // [RULE9]
			unique case (clk_sw)
				2'h1:    clkgen_init <= CLKINIT_POS1; // [RULE9]
				2'h2:    clkgen_init <= CLKINIT_POS2;
				default: clkgen_init <= CLKINIT_POS0;
			endcase
		end
	end

	// ---------------------------------------------
	// Reconfiguration sequencer
	// ---------------------------------------------
	logic [TIMER_W-1:0] timer_r;
	logic               t_done;
	assign t_done = (timer_r == '0);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= S_IDLE;
			timer_r <= '0;
			hard_reset_out_r <= 1'b0;
			cfg_pins <= CFG_PINS_RST;
		end else begin
			if (!t_done) begin
				timer_r <= timer_r - 1'b1;
			end
			unique case (state_r)
				S_IDLE: if (ctrl_r[CTRL_GO]) begin // [RULE11]
					state_r <= S_QUIESCE;
					timer_r <= TIMER_W'(SHORT_CYC - 1); // [RULE12]
				end
				S_QUIESCE: if (t_done) begin
					hard_reset_out_r <= 1'b1; // [RULE12]
					timer_r <= TIMER_W'(LONG_WAIT_CYC - 1);
					state_r <= S_HOLD;
				end
				S_HOLD: if (t_done) state_r <= S_VOLT;
				S_VOLT: if (en_a_r[EN_VOLT]) begin
					cfg_pins.core_voltage_code <= vcore_r; // [RULE13]
					timer_r <= TIMER_W'(SHORT_CYC - 1);
					state_r <= S_VOLT_WAIT;
				end else begin
					state_r <= S_CLK; // [RULE24]
				end
				S_VOLT_WAIT: if (t_done) state_r <= S_CLK;
				S_CLK: if (en_a_r[EN_CLK]) begin
					{cfg_pins.clk_sel_high, cfg_pins.clk_sel_low} <= clksel_r; // [RULE14]
					timer_r <= TIMER_W'(LONG_WAIT_CYC - 1);
					state_r <= S_CLK_WAIT;
				end else begin
					state_r <= S_PPLL; // [RULE24]
				end
				S_CLK_WAIT: if (t_done) state_r <= S_PPLL;
				S_PPLL: begin
					if (en_a_r[EN_PPLL]) cfg_pins.platform_pll_ratio <= speed_b_r[4:0]; // [RULE15]
					state_r <= S_CORE_PLL_CHANGE_ENABLE;
				end
				S_CORE_PLL_CHANGE_ENABLE: begin
					if (en_a_r[EN_CORE_PLL_CHANGE_ENABLE]) cfg_pins.core_pll_ratio <= speed_a_r[5:0]; // [RULE16]
					state_r <= S_REF;
				end
				S_REF: if (en_a_r[EN_REF]) begin
					cfg_pins.reference_clock_select <= speed_a_r[8:6]; // [RULE17]
					timer_r <= TIMER_W'(LONG_WAIT_CYC - 1);
					state_r <= S_REF_WAIT;
				end else begin
					state_r <= S_BOOT_LOCATION; // [RULE24]
				end
				S_REF_WAIT: if (t_done) state_r <= S_BOOT_LOCATION;
				S_BOOT_LOCATION: begin
					if (en_b_r[EN_BOOT_LOCATION]) cfg_pins.boot_location <= boot_r[1:0]; // [RULE18]
					state_r <= S_BOOT_SEQUENCE_SELECT;
				end
				S_BOOT_SEQUENCE_SELECT: begin
					if (en_b_r[EN_BOOT_SEQUENCE_SELECT]) cfg_pins.boot_sequence_select <= boot_r[3:2]; // [RULE18]
					state_r <= S_FLASH;
				end
				S_FLASH: begin
					if (en_b_r[EN_FLASH]) begin
						cfg_pins.flash_map_bit <= boot_r[4]; // [RULE19]
						cfg_pins.flash_bank_bit <= boot_r[5];
					end
					state_r <= S_HOST;
				end
				S_HOST: begin
					if (en_b_r[EN_HOST]) cfg_pins.agent_mode_pin <= speed_b_r[5]; // [RULE20]
					state_r <= S_CTLPIN;
				end
				S_CTLPIN: begin
					if (en_b_r[EN_CTLPIN]) cfg_pins.ctl_mode_pin <= speed_b_r[6]; // [RULE21]
					state_r <= S_RELEASE;
				end
				S_RELEASE: begin
					hard_reset_out_r <= 1'b0; // [RULE22]
					state_r <= S_HELD;
				end
				S_HELD: if (!ctrl_r[CTRL_GO]) state_r <= S_IDLE; // [RULE22]
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	a_idle_go_wait: assert property (@(posedge clk_sys) disable iff (rst) // [RULE11]
		state_r == S_IDLE && !ctrl_r[CTRL_GO] |=> state_r == S_IDLE)
		else $error("sequencer left idle without go");
	sequence quiesce_s;
		state_r == S_IDLE && ctrl_r[CTRL_GO] ##1 !hard_reset_out_r ##24 !hard_reset_out_r;
	endsequence
	a_quiesce_low: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
		state_r == S_QUIESCE |-> !hard_reset_out_r)
		else $error("hard reset asserted during settle");
	a_quiesce_then_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
		quiesce_s |=> hard_reset_out_r)
		else $error("hard reset not asserted after settle");
	a_hold_length: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
		$rose(hard_reset_out_r) |-> state_r == S_HOLD && timer_r == TIMER_W'(LONG_WAIT_CYC - 1))
		else $error("hard reset hold count wrong");
	a_trst_debug: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
		dbg_att |=> !resets.trst)
		else $error("test reset asserted with debugger attached");
	a_trst_nodebug: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
		!dbg_att && sys_rst_r |=> resets.trst && resets.hard)
		else $error("test reset missing without debugger");
	a_oe_unpowered: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
		!pwr_on |=> !drive_oe)
		else $error("drivers enabled while unpowered");
	a_sw_lb_reset: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
		ctrl_r[CTRL_RST_LB] |=> resets.lb)
		else $error("software bus reset not driven");
	a_collide_wait: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
		axi_wr && pci_req && pci_we && !pci_cfg && !pci_ack && pci_idx == aw_idx |=> !pci_ack)
		else $error("colliding target write not stalled");
	a_release_held: assert property (@(posedge clk_sys) disable iff (rst) // [RULE22]
		state_r == S_HELD && ctrl_r[CTRL_GO] |=> state_r == S_HELD && !hard_reset_out_r)
		else $error("sequencer left hold while go set");
	a_volt_skip: assert property (@(posedge clk_sys) disable iff (rst) // [RULE24]
		state_r == S_VOLT && !en_a_r[EN_VOLT] |=> state_r == S_CLK && $stable(cfg_pins.core_voltage_code))
		else $error("disabled voltage step not skipped");
endmodule
`default_nettype wire

/* File: core/brs_pkg.sv */
// Purpose: constants and types for the board reconfiguration reset sequencer
// Assumes: one 25 MHz clock; AXI4-Lite register access
// Notes:   register map, field layout and timing counts live here only
//
// How it works
// RULE1: Debug hard reset spares the JTAG test reset
// RULE2: Without debug header, resets also assert test reset
// RULE3: Collector merges reset requests and power-goods; here core_pg is status only and is not merged
// RULE4: Processor-cpu_out_of_reset_flag flag never starts a reset
// RULE5: Drivers stay off while board unpowered
// RULE6: Software can reset bus, memory, flash separately
// RULE7: Colliding writes from both ports are arbitrated
// RULE8: Not-ready held until access completes; here it is high for one cycle only
// RULE9: Switches map to outputs and clock init
// RULE10: Second port is target-only, reports fixed IDs
// RULE11: Idle step waits for go equal one
// RULE12: Settle 1 us, assert hard reset, hold 200 us
// RULE13: Voltage enable drives code, waits 1 us
// RULE14: Clock enable drives selects, waits 200 us
// RULE15: Platform PLL enable drives its ratio pins
// RULE16: Core PLL enable drives its ratio pins
// RULE17: Reference clock enable drives select, waits 200 us
// RULE18: Boot location, then boot sequence, when enabled
// RULE19: Flash enable drives map and bank pins
// RULE20: Host-mode enable drives agent mode pin
// RULE21: Controller-pin enable drives controller mode pin
// RULE22: Release hard reset, hold until go cleared
// RULE23: Board-side inputs pass two-flop synchronisers
// RULE24: Steps run in order, disabled steps skipped
package brs_pkg;
	// ---------------------------------------------
	// Timing
	// ---------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int SETTLE_SHORT_NS = 1000;
	localparam int SETTLE_LONG_NS = 200000;
	localparam int SHORT_CYC = (SETTLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LONG_CYC = (SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 16;
	localparam int RESET_STRETCH_CYC = SHORT_CYC;
	// ---------------------------------------------
	// Register map (word indices, byte address is index times 4)
	// ---------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_EN_A = 6'h01;
	localparam logic [5:0] IDX_EN_B = 6'h02;
	localparam logic [5:0] IDX_VCORE = 6'h03;
	localparam logic [5:0] IDX_CLKSEL = 6'h04;
	localparam logic [5:0] IDX_SPEED_A = 6'h05;
	localparam logic [5:0] IDX_SPEED_B = 6'h06;
	localparam logic [5:0] IDX_BOOT = 6'h07;
	localparam logic [5:0] IDX_STATUS = 6'h08;
	localparam logic [5:0] IDX_CLKINIT = 6'h09;
	localparam logic [5:0] IDX_ID = 6'h0a;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_RST_LB = 1;
	localparam int CTRL_RST_MEM = 2;
	localparam int CTRL_RST_CF = 3;
	// Enable A fields
	localparam int EN_VOLT = 0;
	localparam int EN_CLK = 1;
	localparam int EN_PPLL = 2;
	localparam int EN_CORE_PLL_CHANGE_ENABLE = 3;
	localparam int EN_REF = 4;
	// Enable B fields
	localparam int EN_BOOT_LOCATION = 0;
	localparam int EN_BOOT_SEQUENCE_SELECT = 1;
	localparam int EN_FLASH = 2;
	localparam int EN_HOST = 3;
	localparam int EN_CTLPIN = 4;
	// Identity, values arbitrary
	localparam logic [15:0] VENDOR_ID = 16'h5a5a;
	localparam logic [15:0] DEVICE_ID = 16'h0001;
	// Clock switch patterns for positions 0 to 2; position 3 also selects CLKINIT_POS0
	localparam logic [15:0] CLKINIT_POS0 = 16'h0421;
	localparam logic [15:0] CLKINIT_POS1 = 16'h0842;
	localparam logic [15:0] CLKINIT_POS2 = 16'h1084;
	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef struct packed {
		logic [6:0] core_voltage_code;
		logic [7:0] clk_sel_high;
		logic [7:0] clk_sel_low;
		logic [4:0] platform_pll_ratio;
		logic [5:0] core_pll_ratio;
		logic [2:0] reference_clock_select;
		logic [1:0] boot_location;
		logic [1:0] boot_sequence_select;
		logic       flash_map_bit;
		logic       flash_bank_bit;
		logic       agent_mode_pin;
		logic       ctl_mode_pin;
	} brs_cfg_pins_t;
	localparam brs_cfg_pins_t CFG_PINS_RST = '0;
	typedef struct packed {
		logic lb;
		logic mem;
		logic cf;
		logic hard;
		logic trst;
	} brs_resets_t;
endpackage

/* File: test/brs_pci_init.sv */
// Purpose: initiator on the target-only register port
// Assumes: request held until the acknowledge is sampled
// Notes:   released index and data lines show inverted data; we and cfg keep their values
`timescale 1ns/10ps
`default_nettype none
module brs_pci_init (
	input  wire logic        clk_sys,
	output logic             pci_req,
	output logic             pci_we,
	output logic             pci_cfg,
	output logic [5:0]       pci_idx,
	output logic [31:0]      pci_wdata,
	input  wire logic        pci_ack,
	input  wire logic [31:0] pci_rdata
);
	// ----------------------------------------
	// One access, bounded wait
	// ----------------------------------------
	initial begin
		pci_req = 1'b0;
		pci_we = 1'b0;
		pci_cfg = 1'b0;
		pci_idx = 6'h3f;
		pci_wdata = 32'hffffffff;
	end
	task automatic access(input logic w, input logic c, input logic [5:0] i, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		ok = 1'b0;
		@(posedge clk_sys);
		pci_req <= 1'b1;
		pci_we <= w;
		pci_cfg <= c;
		pci_idx <= i;
		pci_wdata <= d;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge clk_sys);
			if (pci_ack === 1'b1) begin
				ok = 1'b1;
				q = pci_rdata;
				pci_req <= 1'b0;
				pci_idx <= ~i;
				pci_wdata <= ~d;
			end
		end
	endtask
endmodule
`default_nettype wire

/* File: test/brs_top_bench.sv */
// Purpose: self-checking bench for brs_top
// Assumes: hold counts shortened to 40 cycles
// Notes:   register tasks speak AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module brs_top_bench
	import brs_pkg::*;
;
	localparam int LW = 40;
	logic          clk_sys, rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic          s_arvalid, s_arready, s_rvalid, s_rready, lb_not_ready, pci_req, pci_we, pci_cfg;
	logic          pci_ack, debug_hard_reset_in_n, debug_attached, board_power_ok, cpu_out_of_reset_flag;
	logic          reset_button_n, drive_oe, ok;
	logic [7:0]    s_awaddr, s_araddr;
	logic [31:0]   s_wdata, s_rdata, pci_wdata, pci_rdata, q;
	logic [3:0]    s_wstrb, direct_switch, direct_cfg;
	logic [1:0]    s_bresp, s_rresp, clock_switch;
	logic [5:0]    pci_idx;
	logic [2:0]    power_good;
	logic [15:0]   clkgen_init;
	logic [15:0]   sw_tab [4] = '{CLKINIT_POS0, CLKINIT_POS1, CLKINIT_POS2, CLKINIT_POS0};
	brs_resets_t   resets;
	brs_cfg_pins_t cfg_pins;
	int            errors, samples_checked;

	always #20 clk_sys = ~clk_sys;

	brs_top #(.LONG_WAIT_CYC(LW)) u_brs_top (.clk_sys, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
		.s_rdata, .s_rresp, .s_rvalid, .s_rready, .lb_not_ready, .pci_req, .pci_we, .pci_cfg, .pci_idx,
		.pci_wdata, .pci_ack, .pci_rdata, .debug_hard_reset_in_n, .debug_attached, .board_power_ok,
		.core_supply_power_good(1'b1), .cpu_out_of_reset_flag, .power_good, .reset_button_n, .clock_switch,
		.direct_switch, .resets, .cfg_pins, .direct_cfg, .clkgen_init, .drive_oe);
	brs_pci_init u_brs_pci_init (.clk_sys, .pci_req, .pci_we, .pci_cfg, .pci_idx, .pci_wdata, .pci_ack,
		.pci_rdata);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic hang;
		errors++;
		tally_and_finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (int n = 0; n <= 50; n++) begin
			if (n == 50)
				hang;
			@(posedge clk_sys);
			if (s_awready === 1'b1)
				s_awvalid <= 1'b0;
			if (s_wready === 1'b1)
				s_wvalid <= 1'b0;
			if (s_bvalid === 1'b1) begin
				s_bready <= 1'b0;
				cmp("bresp", er, s_bresp);
				cmp("not_ready", 1, lb_not_ready);
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk_sys);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (int n = 0; n <= 50; n++) begin
			if (n == 50)
				hang;
			@(posedge clk_sys);
			if (s_arready === 1'b1)
				s_arvalid <= 1'b0;
			if (s_rvalid === 1'b1) begin
				s_rready <= 1'b0;
				cmp("rdata", e, s_rdata);
				cmp("rresp", er, s_rresp);
				break;
			end
		end
	endtask
	// Hold length tells which settling waits ran
	task automatic seq_run(input brs_cfg_pins_t e, input int lo, input int hi);
		int n;
		int h;
		n = 0;
		h = 0;
		while (resets.hard !== 1'b1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		cmp("settle", 1, n >= SHORT_CYC - 4 && n < 2000);
		while (resets.hard === 1'b1 && h < 2000) begin
			@(posedge clk_sys);
			h++;
		end
		cmp("hold", 1, h >= lo && h <= hi);
		if (n + h >= 4000)
			hang;
		tick(2);
		cmp("pins", e, cfg_pins);
		tick(50);
		cmp("held", 0, resets.hard);
		cmp("nrdy_idle", 0, lb_not_ready);
		wr(8'h00, 32'h0, RESP_OKAY);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		brs_cfg_pins_t e;
		{clk_sys, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, cpu_out_of_reset_flag} = '0;
		{s_awaddr, s_araddr, s_wdata, clock_switch, direct_switch} = '0;
		{debug_attached, debug_hard_reset_in_n, board_power_ok, reset_button_n} = 4'hf;
		{rst, s_wstrb, power_good} = 8'hff;
		errors = 0;
		samples_checked = 0;
		tick(8);
		rst <= 1'b0;
		tick(60);
		wr(8'h28, 32'h0, RESP_OKAY);
		rd(8'h28, {DEVICE_ID, VENDOR_ID}, RESP_OKAY);
		u_brs_pci_init.access(1'b0, 1'b1, 6'h0, 32'h0, q, ok);
		cmp("pci_id", {1'b1, DEVICE_ID, VENDOR_ID}, {ok, q});
		rd(8'h2c, 32'h0, RESP_SLVERR);
		wr(8'h00, 32'he, RESP_OKAY);
		tick(2);
		cmp("sw_rst", 5'b11100, resets);
		wr(8'h00, 32'h0, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			clock_switch <= i[1:0];
			direct_switch <= 4'h9 ^ i[3:0];
			tick(6);
			cmp("clkgen", sw_tab[i], clkgen_init);
			cmp("direct", 4'h9 ^ i[3:0], direct_cfg);
			rd(8'h24, {16'h0, sw_tab[i]}, RESP_OKAY);
		end
		debug_hard_reset_in_n <= 1'b0;
		tick(6);
		cmp("dbg_rst", 5'b11110, resets);
		debug_hard_reset_in_n <= 1'b1;
		debug_attached <= 1'b0;
		tick(40);
		cmp("idle", 5'b00000, resets);
		reset_button_n <= 1'b0;
		tick(6);
		cmp("btn_rst", 5'b11111, resets);
		reset_button_n <= 1'b1;
		tick(40);
		power_good <= 3'h5;
		tick(6);
		cmp("pg_rst", 5'b11111, resets);
		power_good <= 3'h7;
		tick(40);
		cpu_out_of_reset_flag <= 1'b1;
		tick(6);
		cmp("cpu_out_of_reset_flag", 5'b00000, resets);
		board_power_ok <= 1'b0;
		tick(6);
		cmp("oe_off", 0, drive_oe);
		board_power_ok <= 1'b1;
		tick(40);
		cmp("oe_on", 1, drive_oe);
		fork
			wr(8'h0c, 32'h22, RESP_OKAY);
			u_brs_pci_init.access(1'b1, 1'b0, IDX_VCORE, 32'h33, q, ok);
		join
		rd(8'h0c, 32'h33, RESP_OKAY);
		wr(8'h0c, 32'h55, RESP_OKAY);
		wr(8'h10, 32'ha53c, RESP_OKAY);
		wr(8'h14, 32'h1ab, RESP_OKAY);
		wr(8'h18, 32'h55, RESP_OKAY);
		wr(8'h1c, 32'h39, RESP_OKAY);
		wr(8'h04, 32'h1f, RESP_OKAY);
		wr(8'h08, 32'h1f, RESP_OKAY);
		wr(8'h00, 32'h1, RESP_OKAY);
		e = '{7'h55, 8'ha5, 8'h3c, 5'h15, 6'h2b, 3'h6, 2'h1, 2'h2, 1'b1, 1'b1, 1'b0, 1'b1};
		seq_run(e, 3 * LW + SHORT_CYC, 3 * LW + SHORT_CYC + 20);
		wr(8'h0c, 32'h11, RESP_OKAY);
		wr(8'h1c, 32'h02, RESP_OKAY);
		wr(8'h04, 32'h0, RESP_OKAY);
		wr(8'h08, 32'h1, RESP_OKAY);
		wr(8'h00, 32'h1, RESP_OKAY);
		e.boot_location = 2'h2;
		seq_run(e, LW, LW + 20);
		tally_and_finish;
	end
endmodule
`default_nettype wire
